// ===== include/rcc_pkg.sv
// Notes on behaviour
// - mode bit 7 of mode_and_channel: 0 receive, 1 transmit
// - channel bits 6:0 give 2400 MHz plus channel
// - power bits 4:3 select -20 to 0 dBm
// - bit 6 of data_function_control: 0 continuous, 1 burst
// - bit 5 of data_function_control: 0 250 kb/s, 1 1 Mb/s
// - bit 4 burst scrambling, x^7+x^4+1
// - bit 3 burst CRC-16, x^16+x^12+x^5+1
// - CRC fail clears FIFO unless bit 0 set
// - continuous mode: bit 4 of signal_strength_control refreshes level
// - detect pin high when level exceeds threshold
// - continuous mode: bit 5 of signal_strength_value enables gain control
// - continuous mode: bit 4 of signal_strength_value, 1 low gain
// - bits 3:0 of signal_strength_value show digitised level
// - two bytes, MSB first: write flag, address, data
`default_nettype none
package rcc_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [6:0] OFS_MODE_CHAN  = 7'h00;
   localparam logic [6:0] OFS_PWR_XTAL   = 7'h01;
   localparam logic [6:0] OFS_DATA_FUNC  = 7'h02;
   localparam logic [6:0] OFS_STR_CTRL   = 7'h03;
   localparam logic [6:0] OFS_STR_VALUE  = 7'h04;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_MODE_CHAN  = 8'h28;
   localparam logic [7:0] RST_PWR_XTAL   = 8'h03;
   localparam logic [7:0] RST_DATA_FUNC  = 8'h78;
   localparam logic [7:0] RST_STR_CTRL   = 8'h87;
   localparam logic [7:0] RST_STR_VALUE  = 8'h20;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_CHIP_MODE   = 7;
   localparam int CHAN_MSB        = 6;
   localparam int PWR_MSB         = 4;
   localparam int PWR_LSB         = 3;
   localparam int XTAL_MSB        = 2;
   localparam int BIT_BURST       = 6;
   localparam int BIT_RATE        = 5;
   localparam int BIT_SCRAMBLE    = 4;
   localparam int BIT_CRC         = 3;
   localparam int BIT_CRC_KEEP    = 0;
   localparam int BIT_REFRESH     = 4;
   localparam int THR_MSB         = 3;
   localparam int BIT_AGC         = 5;
   localparam int BIT_GAIN        = 4;
   localparam int LEVEL_MSB       = 3;

   // ----------------------------------------
   // serial framing and data path constants
   // ----------------------------------------
   localparam logic [4:0]  BITS_PER_BYTE  = 5'h08;
   localparam logic [4:0]  BITS_PER_XFER  = 5'h10;
   localparam logic [6:0]  SCR_SEED       = 7'h7F;
   localparam logic [15:0] CRC_SEED       = 16'hFFFF;
   localparam logic [15:0] CRC_POLY       = 16'h1021;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} rcc_state_type;

endpackage
`default_nettype wire

// ===== rtl/rcc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rcc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ----------------------------------------
   // two flops per bit
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_reg;
         logic meta_next;
         logic stab_reg;
         logic stab_next;
         // first flop is read only by the second
         always_comb begin
            meta_next = async_in[gi];
            stab_next = meta_reg;
         end
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               meta_reg <= 1'b0;
               stab_reg <= 1'b0;
            end else begin
               meta_reg <= meta_next;
               stab_reg <= stab_next;
            end
         end
         assign sync_out[gi] = stab_reg;
      end
   endgenerate

endmodule
`default_nettype wire

// ===== rtl/rcc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module rcc_config_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // three-wire serial port pins
   input  wire logic        cs_pin,
   input  wire logic        sclk_pin,
   input  wire logic        sdat_in,
   output logic             sdat_out,
   output logic             sdat_oe,
   // analog front end
   input  wire logic [3:0]  analog_strength_level,
   output logic             strength_detect_pin,
   output logic             auto_gain_enable,
   output logic             strength_gain_select,
   // radio configuration
   output logic             chip_transmit,
   output logic [6:0]       channel_number,
   output logic [1:0]       output_power_level,
   output logic [2:0]       reference_freq_select,
   output logic             burst_mode,
   output logic             bit_rate_select,
   output logic             scramble_enable,
   output logic             crc_enable,
   // bit-serial packet path
   input  wire logic        frame_start,
   input  wire logic        bit_valid,
   input  wire logic        bit_in,
   input  wire logic        packet_end,
   input  wire logic [15:0] rx_crc,
   output logic             scr_bit_out,
   output logic [15:0]      crc_value,
   output logic             crc_good,
   output logic             fifo_clear
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [6:0] sync_vec;
   rcc_sync #(.WIDTH(7)) u_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .async_in ({analog_strength_level, sdat_in, sclk_pin, cs_pin}),
      .sync_out (sync_vec)
   );
   logic       cs_s;
   logic       sclk_s;
   logic       sdat_s;
   logic [3:0] level_s;
   assign cs_s    = sync_vec[0];
   assign sclk_s  = sync_vec[1];
   assign sdat_s  = sync_vec[2];
   assign level_s = sync_vec[6:3];

   // ----------------------------------------
   // serial shifter state
   // ----------------------------------------
   rcc_pkg::rcc_state_type state_reg, state_next;
   logic       sclk_d_reg, sclk_d_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [7:0] sin_reg, sin_next;
   logic [7:0] sout_reg, sout_next;
   logic       wr_reg, wr_next;
   logic [6:0] addr_reg, addr_next;
   logic       rise;
   logic       fall;
   logic       wr_strobe;
   logic [7:0] wr_data;

   // ----------------------------------------
   // register bank state
   // ----------------------------------------
   logic [7:0] mode_chan_reg, mode_chan_next;
   logic [7:0] pwr_xtal_reg, pwr_xtal_next;
   logic [7:0] data_func_reg, data_func_next;
   logic [7:0] str_ctrl_reg, str_ctrl_next;
   logic [3:0] str_hi_reg, str_hi_next;
   logic [3:0] held_reg, held_next;
   logic       detect_reg, detect_next;

   // read mux shared by the shifter load
   function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] r0,
         input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3,
         input logic [7:0] r4);
      case (a)
         rcc_pkg::OFS_MODE_CHAN: read_mux = r0;
         rcc_pkg::OFS_PWR_XTAL:  read_mux = r1;
         rcc_pkg::OFS_DATA_FUNC: read_mux = r2;
         rcc_pkg::OFS_STR_CTRL:  read_mux = r3;
         rcc_pkg::OFS_STR_VALUE: read_mux = r4;
         default:                read_mux = 8'h00;
      endcase
   endfunction

   assign rise = sclk_s & ~sclk_d_reg;
   assign fall = ~sclk_s & sclk_d_reg;

   // address byte then data byte, msb first; cs low aborts the transfer
   always_comb begin
      state_next  = state_reg;
      sclk_d_next = sclk_s;
      cnt_next    = cnt_reg;
      sin_next    = sin_reg;
      sout_next   = sout_reg;
      wr_next     = wr_reg;
      addr_next   = addr_reg;
      wr_strobe   = 1'b0;
      wr_data     = {sin_reg[6:0], sdat_s};
      case (state_reg)
         rcc_pkg::ST_IDLE: begin
            cnt_next = 5'h00;
            if (cs_s) begin
               state_next = rcc_pkg::ST_ADDR;
            end
         end
         rcc_pkg::ST_ADDR: begin
            if (!cs_s) begin
               state_next = rcc_pkg::ST_IDLE;
            end else if (rise) begin
               sin_next = {sin_reg[6:0], sdat_s};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == rcc_pkg::BITS_PER_BYTE - 5'h01) begin
                  wr_next    = sin_reg[6];
                  addr_next  = {sin_reg[5:0], sdat_s};
                  sout_next  = read_mux({sin_reg[5:0], sdat_s}, mode_chan_reg, pwr_xtal_reg,
                                        data_func_reg, str_ctrl_reg, {str_hi_reg, held_reg});
                  state_next = rcc_pkg::ST_DATA;
               end
            end
         end
         rcc_pkg::ST_DATA: begin
            if (!cs_s) begin
               state_next = rcc_pkg::ST_IDLE;
            end else if (rise && cnt_reg < rcc_pkg::BITS_PER_XFER) begin
               sin_next = {sin_reg[6:0], sdat_s};
               cnt_next = cnt_reg + 5'h01;
               // last data bit commits a write; no address auto increment
               if (cnt_reg == rcc_pkg::BITS_PER_XFER - 5'h01) begin
                  wr_strobe = wr_reg;
               end
            end else if (fall && cnt_reg > rcc_pkg::BITS_PER_BYTE) begin
               sout_next = {sout_reg[6:0], 1'b0};
            end
         end
         default: begin
            state_next = rcc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg  <= rcc_pkg::ST_IDLE;
         sclk_d_reg <= 1'b0;
         cnt_reg    <= 5'h00;
         sin_reg    <= 8'h00;
         sout_reg   <= 8'h00;
         wr_reg     <= 1'b0;
         addr_reg   <= 7'h00;
      end else begin
         state_reg  <= state_next;
         sclk_d_reg <= sclk_d_next;
         cnt_reg    <= cnt_next;
         sin_reg    <= sin_next;
         sout_reg   <= sout_next;
         wr_reg     <= wr_next;
         addr_reg   <= addr_next;
      end
   end

   // drive the data byte only while a read is in its data phase
   assign sdat_oe  = (state_reg == rcc_pkg::ST_DATA) && !wr_reg &&
                     (cnt_reg < rcc_pkg::BITS_PER_XFER);
   assign sdat_out = sout_reg[7];

   // ----------------------------------------
   // register bank and strength logic
   // ----------------------------------------
   // bits 3:0 of the value register are not stored: they show the held level
   always_comb begin
      mode_chan_next = mode_chan_reg;
      pwr_xtal_next  = pwr_xtal_reg;
      data_func_next = data_func_reg;
      str_ctrl_next  = str_ctrl_reg;
      str_hi_next    = str_hi_reg;
      if (wr_strobe) begin
         case (addr_reg)
            rcc_pkg::OFS_MODE_CHAN: mode_chan_next = wr_data;
            rcc_pkg::OFS_PWR_XTAL:  pwr_xtal_next  = wr_data;
            rcc_pkg::OFS_DATA_FUNC: data_func_next = wr_data;
            rcc_pkg::OFS_STR_CTRL:  str_ctrl_next  = wr_data;
            rcc_pkg::OFS_STR_VALUE: str_hi_next    = wr_data[7:4];
            default: begin
               str_hi_next = str_hi_reg;
            end
         endcase
      end
      // burst mode always tracks; continuous mode follows the refresh bit
      held_next = (!burst_mode && !str_ctrl_reg[rcc_pkg::BIT_REFRESH]) ? held_reg
                                                                      : level_s;
      detect_next = held_reg > str_ctrl_reg[rcc_pkg::THR_MSB:0];
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_chan_reg <= rcc_pkg::RST_MODE_CHAN;
         pwr_xtal_reg  <= rcc_pkg::RST_PWR_XTAL;
         data_func_reg <= rcc_pkg::RST_DATA_FUNC;
         str_ctrl_reg  <= rcc_pkg::RST_STR_CTRL;
         str_hi_reg    <= rcc_pkg::RST_STR_VALUE[7:4];
         held_reg      <= rcc_pkg::RST_STR_VALUE[3:0];
         detect_reg    <= 1'b0;
      end else begin
         mode_chan_reg <= mode_chan_next;
         pwr_xtal_reg  <= pwr_xtal_next;
         data_func_reg <= data_func_next;
         str_ctrl_reg  <= str_ctrl_next;
         str_hi_reg    <= str_hi_next;
         held_reg      <= held_next;
         detect_reg    <= detect_next;
      end
   end

   // ----------------------------------------
   // configuration outputs
   // ----------------------------------------
   assign chip_transmit         = mode_chan_reg[rcc_pkg::BIT_CHIP_MODE];
   assign channel_number        = mode_chan_reg[rcc_pkg::CHAN_MSB:0];
   assign output_power_level    = pwr_xtal_reg[rcc_pkg::PWR_MSB:rcc_pkg::PWR_LSB];
   assign reference_freq_select = pwr_xtal_reg[rcc_pkg::XTAL_MSB:0];
   assign burst_mode            = data_func_reg[rcc_pkg::BIT_BURST];
   assign bit_rate_select       = data_func_reg[rcc_pkg::BIT_RATE];
   assign scramble_enable       = burst_mode & data_func_reg[rcc_pkg::BIT_SCRAMBLE];
   assign crc_enable            = burst_mode & data_func_reg[rcc_pkg::BIT_CRC];
   assign auto_gain_enable      = !burst_mode & str_hi_reg[rcc_pkg::BIT_AGC - 4];
   assign strength_gain_select  = !burst_mode & str_hi_reg[rcc_pkg::BIT_GAIN - 4];
   assign strength_detect_pin   = detect_reg;

   // ----------------------------------------
   // scrambler and crc engine
   // ----------------------------------------
   logic [6:0]  scr_reg, scr_next;
   logic        sbit_reg, sbit_next;
   logic [15:0] crc_reg, crc_next;
   logic        good_reg, good_next;
   logic        clear_reg, clear_next;
   logic        scr_fb;
   logic        crc_fb;
   logic        crc_bad;

   // both shift registers restart from all ones at every frame start
   always_comb begin
      scr_next   = scr_reg;
      sbit_next  = sbit_reg;
      crc_next   = crc_reg;
      scr_fb     = scr_reg[6] ^ scr_reg[3];
      crc_fb     = crc_reg[15] ^ bit_in;
      crc_bad    = crc_enable && !chip_transmit && (crc_reg != rx_crc);
      good_next  = packet_end && crc_enable && !chip_transmit && !crc_bad;
      clear_next = packet_end && crc_bad &&
                   !data_func_reg[rcc_pkg::BIT_CRC_KEEP];
      if (frame_start) begin
         scr_next = rcc_pkg::SCR_SEED;
         crc_next = rcc_pkg::CRC_SEED;
      end else if (bit_valid) begin
         scr_next  = {scr_reg[5:0], scr_fb};
         sbit_next = scramble_enable ? (bit_in ^ scr_fb) : bit_in;
         if (crc_enable) begin
            crc_next = {crc_reg[14:0], 1'b0} ^ (crc_fb ? rcc_pkg::CRC_POLY : 16'h0000);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scr_reg   <= rcc_pkg::SCR_SEED;
         sbit_reg  <= 1'b0;
         crc_reg   <= rcc_pkg::CRC_SEED;
         good_reg  <= 1'b0;
         clear_reg <= 1'b0;
      end else begin
         scr_reg   <= scr_next;
         sbit_reg  <= sbit_next;
         crc_reg   <= crc_next;
         good_reg  <= good_next;
         clear_reg <= clear_next;
      end
   end

   assign scr_bit_out = sbit_reg;
   assign crc_value   = crc_reg;
   assign crc_good    = good_reg;
   assign fifo_clear  = clear_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence seq_addr_done;
      state_reg == rcc_pkg::ST_ADDR && cs_s && rise && cnt_reg == 5'h07;
   endsequence
   sequence seq_write_commit;
      wr_strobe && addr_reg == rcc_pkg::OFS_MODE_CHAN;
   endsequence

   AST_MODE_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      chip_transmit == mode_chan_reg[7] && channel_number == mode_chan_reg[6:0])
      else $error("mode or channel output does not follow register");
   AST_WRITE_LANDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
      seq_write_commit |=> mode_chan_reg == $past(wr_data))
      else $error("write to mode register did not land");
   AST_PWR_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      output_power_level == pwr_xtal_reg[4:3])
      else $error("power level not taken from bits 4:3");
   AST_BURST_GATES: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !data_func_reg[6] |-> !scramble_enable && !crc_enable ##1 !fifo_clear)
      else $error("burst-only function active in continuous mode");
   AST_RATE_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $changed(data_func_reg) |-> bit_rate_select == data_func_reg[5])
      else $error("rate select does not follow bit 5");
   AST_SCR_SEED: assert property (@(posedge ref_clk) disable iff (sys_rst)
      frame_start |=> scr_reg == 7'h7F && crc_reg == 16'hFFFF)
      else $error("shift registers not seeded to ones");
   AST_CRC_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !crc_enable && !frame_start |=> $stable(crc_reg))
      else $error("crc moved while disabled");
   AST_FIFO_CLEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
      packet_end && crc_enable && !chip_transmit && crc_reg != rx_crc
      && !data_func_reg[0] |=> fifo_clear ##1 !fifo_clear)
      else $error("failed packet did not clear fifo for one cycle");
   AST_HOLD_LEVEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !burst_mode && !str_ctrl_reg[4] |=> held_reg == $past(held_reg))
      else $error("held level changed without refresh");
   AST_DETECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      held_reg > str_ctrl_reg[3:0] |=> strength_detect_pin)
      else $error("detect pin low above threshold");
   AST_AGC: assert property (@(posedge ref_clk) disable iff (sys_rst)
      auto_gain_enable |-> !burst_mode && str_hi_reg[1])
      else $error("gain control active wrongly");
   AST_GAIN: assert property (@(posedge ref_clk) disable iff (sys_rst)
      strength_gain_select |-> !burst_mode && str_hi_reg[0])
      else $error("gain select active wrongly");
   AST_READ_VALUE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      seq_addr_done ##0 (!sin_reg[6] && {sin_reg[5:0], sdat_s} == 7'h04)
      |=> sout_reg[3:0] == $past(held_reg))
      else $error("value read does not show held level");
   AST_NO_DRIVE_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      seq_addr_done ##1 wr_reg |-> !sdat_oe)
      else $error("pin driven during a write");

endmodule
`default_nettype wire

// ===== bench/rcc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module rcc_host_model (
   // clock
   input  wire logic ref_clk,
   // serial pins seen by the host
   input  wire logic sdat_out,
   input  wire logic sdat_oe,
   output logic      cs_pin,
   output logic      sclk_pin,
   output logic      sdat_line
);
   logic drv;
   logic bit_o;
   logic tog;
   initial begin
      cs_pin = 1'b0;
      sclk_pin = 1'b0;
      drv = 1'b0;
      bit_o = 1'b0;
      tog = 1'b0;
   end
   // a released line toggles every cycle so a stale bit never reads as valid
   always @(posedge ref_clk) begin
      tog <= ~tog;
   end
   assign sdat_line = sdat_oe ? sdat_out : (drv ? bit_o : tog);
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // one frame, msb first; clock idles low outside frames
   task automatic xfer(input logic wr, input logic [6:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {wr, adr, wd};
      rd = 8'h00;
      step(1);
      cs_pin = 1'b1;
      step(4);
      for (int i = 15; i >= 0; i--) begin
         drv = (i > 7) || wr;
         bit_o = sh[i];
         step(6); // six cycles, well above the three-cycle minimum
         if (i < 8 && !wr) rd[i] = sdat_line;
         sclk_pin = 1'b1;
         step(6);
         sclk_pin = 1'b0;
      end
      step(4);
      cs_pin = 1'b0;
      drv = 1'b0;
      step(4);
   endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        ref_clk, sys_rst, cs_pin, sclk_pin, sdat_line, sdat_out, sdat_oe;
   logic [3:0]  analog_strength_level;
   logic        strength_detect_pin, auto_gain_enable, strength_gain_select, chip_transmit;
   logic [6:0]  channel_number;
   logic [1:0]  output_power_level;
   logic [2:0]  reference_freq_select;
   logic        burst_mode, bit_rate_select, scramble_enable, crc_enable;
   logic        frame_start, bit_valid, bit_in, packet_end, scr_bit_out, crc_good, fifo_clear;
   logic [15:0] rx_crc, crc_value;
   int          err_total, tests_run, cycles;
   logic [3:0]  func_bits;
   assign func_bits = {burst_mode, bit_rate_select, scramble_enable, crc_enable};

   rcc_config_regs i_dut (.ref_clk, .sys_rst, .cs_pin, .sclk_pin, .sdat_in(sdat_line),
      .sdat_out, .sdat_oe, .analog_strength_level, .strength_detect_pin, .auto_gain_enable,
      .strength_gain_select, .chip_transmit, .channel_number, .output_power_level,
      .reference_freq_select, .burst_mode, .bit_rate_select, .scramble_enable, .crc_enable,
      .frame_start, .bit_valid, .bit_in, .packet_end, .rx_crc, .scr_bit_out, .crc_value,
      .crc_good, .fifo_clear);
   rcc_host_model i_host (.ref_clk, .sdat_out, .sdat_oe, .cs_pin, .sclk_pin, .sdat_line);

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;
   // ceiling nearly four times the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] junk;
      i_host.xfer(1'b1, a, d, junk);
   endtask
   task automatic rdc(input string nm, input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_host.xfer(1'b0, a, 8'h00, v);
      chk(nm, 16'(exp), 16'(v));
   endtask
   // independent bitwise ccitt reference, seeded with all ones
   function automatic logic [15:0] crc_of(input logic [15:0] d);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   // additive scrambler reference, restarted from all ones at each frame
   task automatic send(input logic [15:0] d, input logic [15:0] rc, input logic scr);
      logic [6:0]  s;
      logic [15:0] want;
      logic [15:0] seen;
      s = 7'h7F;
      frame_start = 1'b1;
      step(1);
      frame_start = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         bit_valid = 1'b1;
         bit_in = d[i];
         want[i] = d[i] ^ (scr & (s[6] ^ s[3]));
         s = {s[5:0], s[6] ^ s[3]};
         step(1);
         seen[i] = scr_bit_out;
      end
      bit_valid = 1'b0;
      chk("scr_bit_out", want, seen);
      chk("crc_value", crc_of(d), crc_value);
      rx_crc = rc;
      packet_end = 1'b1;
      step(1);
      packet_end = 1'b0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdc("mode_and_channel", rcc_pkg::OFS_MODE_CHAN, 8'h28);
      rdc("power_and_crystal", rcc_pkg::OFS_PWR_XTAL, 8'h03);
      rdc("data_function_control", rcc_pkg::OFS_DATA_FUNC, 8'h78);
      rdc("signal_strength_control", rcc_pkg::OFS_STR_CTRL, 8'h87);
      rdc("signal_strength_value", rcc_pkg::OFS_STR_VALUE, 8'h20);
      chk("channel_number", 16'h0028, 16'(channel_number));
      $display("test reset_values done");
   endtask
   task automatic t_fields();
      wr(rcc_pkg::OFS_MODE_CHAN, 8'hFF);
      chk("mode_chan", 16'h00FF, 16'({chip_transmit, channel_number}));
      for (int p = 0; p < 5; p++) begin
         wr(rcc_pkg::OFS_PWR_XTAL, 8'({p[1:0], p[2:0]}));
         chk("output_power_level", 16'(p[1:0]), 16'(output_power_level));
         chk("reference_freq_select", 16'(p[2:0]), 16'(reference_freq_select));
      end
      wr(rcc_pkg::OFS_DATA_FUNC, 8'h58);
      chk("data_func", 16'h000B, 16'(func_bits));
      wr(rcc_pkg::OFS_DATA_FUNC, 8'h38); // continuous: burst-only enables must drop
      chk("data_func", 16'h0004, 16'(func_bits));
      $display("test field_decode done");
   endtask
   task automatic t_strength();
      wr(rcc_pkg::OFS_STR_CTRL, 8'h15);
      analog_strength_level = 4'h6;
      step(8);
      chk("strength_detect_pin", 16'h0001, 16'(strength_detect_pin));
      analog_strength_level = 4'h5;
      step(8);
      chk("strength_detect_pin", 16'h0000, 16'(strength_detect_pin));
      wr(rcc_pkg::OFS_STR_CTRL, 8'h05);
      analog_strength_level = 4'hF;
      step(8);
      chk("strength_detect_pin", 16'h0000, 16'(strength_detect_pin));
      rdc("signal_strength_value", rcc_pkg::OFS_STR_VALUE, 8'h25);
      wr(rcc_pkg::OFS_STR_VALUE, 8'h1A);
      chk("gain", 16'h0001, 16'({auto_gain_enable, strength_gain_select}));
      rdc("signal_strength_value", rcc_pkg::OFS_STR_VALUE, 8'h15);
      wr(rcc_pkg::OFS_STR_VALUE, 8'h20);
      chk("gain", 16'h0002, 16'({auto_gain_enable, strength_gain_select}));
      $display("test strength done");
   endtask
   task automatic t_unmapped();
      wr(7'h10, 8'hA5);
      rdc("unmapped", 7'h10, 8'h00);
      rdc("mode_and_channel", rcc_pkg::OFS_MODE_CHAN, 8'hFF);
      $display("test unmapped done");
   endtask
   task automatic t_crc();
      wr(rcc_pkg::OFS_MODE_CHAN, 8'h28);
      wr(rcc_pkg::OFS_DATA_FUNC, 8'h48);
      send(16'hA53C, crc_of(16'hA53C), 1'b0);
      chk("good_clear", 16'h0002, 16'({crc_good, fifo_clear}));
      send(16'h0F1E, ~crc_of(16'h0F1E), 1'b0);
      chk("good_clear", 16'h0001, 16'({crc_good, fifo_clear}));
      wr(rcc_pkg::OFS_DATA_FUNC, 8'h49); // keep data on failure
      send(16'h0F1E, ~crc_of(16'h0F1E), 1'b0);
      chk("good_clear", 16'h0000, 16'({crc_good, fifo_clear}));
      wr(rcc_pkg::OFS_DATA_FUNC, 8'h59); // scrambled line, crc over plain bits
      send(16'hC3A5, crc_of(16'hC3A5), 1'b1);
      chk("good_clear", 16'h0002, 16'({crc_good, fifo_clear}));
      $display("test crc_policy done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      analog_strength_level = 4'h0;
      {frame_start, bit_valid, bit_in, packet_end} = 4'h0;
      rx_crc = 16'h0000;
      step(3);
      sys_rst = 1'b0;
      step(3);
      t_reset();
      t_fields();
      t_strength();
      t_unmapped();
      t_crc();
      close_out();
   end
endmodule
`default_nettype wire
